// file: verilog/fault_mgr_pkg.sv
// constants and types shared by the fault manager files
package fault_mgr_pkg;
	localparam int          CLK_HZ             = 50_000_000;
	localparam int          OC_DEGLITCH_NS     = 600;
	localparam int          OC_DEGLITCH_CYC    = (OC_DEGLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int          RETRY_US           = 5000;
	localparam int          RETRY_CYC          = RETRY_US * (CLK_HZ / 1_000_000);
	localparam int          BUCK_RETRY_US      = 5000;
	localparam int          BUCK_RETRY_CYC     = BUCK_RETRY_US * (CLK_HZ / 1_000_000);
	localparam int          SLEEP_US           = 100;
	localparam int          SLEEP_CYC          = SLEEP_US * (CLK_HZ / 1_000_000);
	localparam int          WAKE_US            = 100;
	localparam int          WAKE_CYC           = WAKE_US * (CLK_HZ / 1_000_000);
	localparam int          RST_PULSE_US       = 40;
	localparam int          RST_PULSE_CYC      = RST_PULSE_US * (CLK_HZ / 1_000_000);
	localparam int          OV_THRESH_LOW_V    = 22;
	localparam int          OV_THRESH_HIGH_V   = 34;
	localparam logic [1:0]  OC_MODE_LATCH      = 2'h0;
	localparam logic [1:0]  OC_MODE_RETRY      = 2'h1;
	localparam logic [1:0]  OC_MODE_REPORT     = 2'h2;
	localparam logic [1:0]  OC_MODE_OFF        = 2'h3;
	localparam logic [1:0]  OC_DEG_RESET       = 2'h0;
	localparam int          CNT_W              = 24;
	typedef enum logic [2:0] {ST_SLEEP, ST_WAKE, ST_RUN, ST_LOW, ST_ENTER} pwr_state_t;
endpackage

// file: verilog/sync2.sv
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module sync2 (
	input  wire logic i_clk_sys,
	input  wire logic i_rst_b,
	input  wire logic i_ce,
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta_q;
	// first stage feeds only the second
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= 1'b0;
			o_sync <= 1'b0;
		end else if (i_ce) begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule

// file: verilog/deglitch.sv
// qualifies a level only after it has held for a cycle count
`timescale 1ns/100ps
module deglitch
	import fault_mgr_pkg::*;
(
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst_b,
	input  wire logic             i_ce,
	input  wire logic             i_level,
	input  wire logic [CNT_W-1:0] i_hold_cyc,
	output logic                  o_event
);
	logic [CNT_W-1:0] cnt_q;
	// counter restarts whenever the raw level drops
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_q   <= '0;
			o_event <= 1'b0;
		end else if (i_ce) begin
			if (!i_level) begin
				cnt_q   <= '0;
				o_event <= 1'b0;
			end else if (cnt_q >= i_hold_cyc) begin
				o_event <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule

// file: verilog/motor_driver_fault_manager.sv
// fault supervision and sleep control for a three-phase driver
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
module motor_driver_fault_manager
	import fault_mgr_pkg::*;
#(
	parameter int RETRY_CYCLES      = RETRY_CYC,
	parameter int BUCK_RETRY_CYCLES = BUCK_RETRY_CYC,
	parameter int SLEEP_CYCLES      = SLEEP_CYC,
	parameter int WAKE_CYCLES       = WAKE_CYC,
	parameter int RST_PULSE_CYCLES  = RST_PULSE_CYC
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_b,
	input  wire logic        i_ce,
	input  wire logic        i_pin_variant,
	input  wire logic        i_sleep_n,
	input  wire logic        i_driver_disable_pin,
	input  wire logic        i_pump_uv,
	input  wire logic        i_vm_above_22,
	input  wire logic        i_vm_above_34,
	input  wire logic [5:0]  i_fet_oc,
	input  wire logic        i_buck_oc,
	input  wire logic        i_temp_warn,
	input  wire logic        i_temp_warn_hys,
	input  wire logic        i_tsd_fet,
	input  wire logic        i_tsd_die,
	input  wire logic [4:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [7:0]  o_reg_rdata,
	output logic             o_fault_out_n,
	output logic             o_bridge_enable,
	output logic             o_buck_enable,
	output logic             o_pump_enable,
	output logic             o_regulators_enable,
	output logic             o_ready
);
	// register map of this block
	localparam logic [4:0] ADDR_STATUS  = 5'h00;
	localparam logic [4:0] ADDR_FET_OC  = 5'h01;
	localparam logic [4:0] ADDR_STAT2   = 5'h02;
	localparam logic [4:0] ADDR_CTRL    = 5'h03;
	localparam logic [4:0] ADDR_OCCFG   = 5'h04;
	localparam logic [4:0] ADDR_CLEAR   = 5'h05;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] OCCFG_RESET  = 8'h00;

	// synchronised pins and monitors
	logic sleep_s, driver_disable_pin_s, pump_undervolt_protection_s, ov22_s, ov34_s, buck_oc_s;
	logic warn_s, warn_hys_s, tsdf_s, tsdd_s;
	logic [5:0] fet_oc_s;
	logic [5:0] fet_oc_ev;
	logic       buck_oc_ev;

	sync2 u_s_sleep (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_async(i_sleep_n), .o_sync(sleep_s));
	sync2 u_s_driver_disable_pin (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_async(i_driver_disable_pin), .o_sync(driver_disable_pin_s));
	sync2 u_s_pump_undervolt_protection (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_async(i_pump_uv), .o_sync(pump_undervolt_protection_s));
	sync2 u_s_ov22 (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_async(i_vm_above_22), .o_sync(ov22_s));
	sync2 u_s_ov34 (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_async(i_vm_above_34), .o_sync(ov34_s));
	sync2 u_s_boc (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_async(i_buck_oc), .o_sync(buck_oc_s));
	sync2 u_s_warn (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_async(i_temp_warn), .o_sync(warn_s));
	sync2 u_s_hys (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_async(i_temp_warn_hys), .o_sync(warn_hys_s));
	sync2 u_s_tsdf (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_async(i_tsd_fet), .o_sync(tsdf_s));
	sync2 u_s_tsdd (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_async(i_tsd_die), .o_sync(tsdd_s));

	// software settings
	logic [7:0] ctrl_q;
	logic [7:0] occfg_q;
	logic       ov_en, ov_sel, warn_rep;
	logic [1:0] oc_mode;
	logic [1:0] oc_deg_sel;
	logic [CNT_W-1:0] oc_hold;

	// pin variant forces fixed overvoltage and latched overcurrent
	assign ov_en      = i_pin_variant | ctrl_q[0];
	assign ov_sel     = i_pin_variant | ctrl_q[1];
	assign warn_rep   = ~i_pin_variant & ctrl_q[2];
	assign oc_mode    = i_pin_variant ? OC_MODE_LATCH : occfg_q[1:0];
	assign oc_deg_sel = i_pin_variant ? OC_DEG_RESET : occfg_q[3:2];

	// deglitch choices scale the fixed figure by 1,2,4,8
	function automatic logic [CNT_W-1:0] deg_cycles(input logic [1:0] sel);
		deg_cycles = CNT_W'(OC_DEGLITCH_CYC) << sel;
	endfunction
	assign oc_hold = deg_cycles(oc_deg_sel);

	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_fet
			deglitch u_dg (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
				.i_level(fet_oc_s[g]), .i_hold_cyc(oc_hold), .o_event(fet_oc_ev[g]));
			sync2 u_s (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
				.i_async(i_fet_oc[g]), .o_sync(fet_oc_s[g]));
		end
	endgenerate
	deglitch u_dg_buck (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_level(buck_oc_s), .i_hold_cyc(oc_hold), .o_event(buck_oc_ev));

	// power state, sleep pulse timing
	pwr_state_t       st_q;
	logic [CNT_W-1:0] pcnt_q;
	logic             pulse_clear;
	logic             operating;
	assign operating = (st_q == ST_RUN) || (st_q == ST_LOW);

	// low shorter than the pulse window only clears faults
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q        <= ST_SLEEP;
			pcnt_q      <= '0;
			pulse_clear <= 1'b0;
		end else if (i_ce) begin
			pulse_clear <= 1'b0;
			case (st_q)
				ST_SLEEP: begin
					pcnt_q <= '0;
					if (sleep_s) st_q <= ST_WAKE;
				end
				ST_WAKE: begin
					if (!sleep_s) begin
						st_q   <= ST_ENTER;
						pcnt_q <= '0;
					end else if (pcnt_q >= CNT_W'(WAKE_CYCLES - 1)) begin
						st_q   <= ST_RUN;
						pcnt_q <= '0;
					end else begin
						pcnt_q <= pcnt_q + 1'b1;
					end
				end
				ST_RUN: begin
					pcnt_q <= '0;
					if (!sleep_s) st_q <= ST_LOW;
				end
				ST_LOW: begin
					if (sleep_s) begin
						pulse_clear <= 1'b1;
						st_q        <= ST_RUN;
					end else if (pcnt_q >= CNT_W'(RST_PULSE_CYCLES - 1)) begin
						st_q   <= ST_ENTER;
						pcnt_q <= '0;
					end else begin
						pcnt_q <= pcnt_q + 1'b1;
					end
				end
				ST_ENTER: begin
					if (pcnt_q >= CNT_W'(SLEEP_CYCLES - 1)) begin
						st_q   <= ST_SLEEP;
						pcnt_q <= '0;
					end else begin
						pcnt_q <= pcnt_q + 1'b1;
					end
				end
				default: st_q <= ST_SLEEP;
			endcase
		end
	end

	// clear request: software bit or short sleep pulse
	logic sw_clear, clear_any, in_sleep;
	assign sw_clear  = i_reg_wr && (i_reg_addr == ADDR_CLEAR) && i_reg_wdata[0] && !i_pin_variant;
	assign clear_any = sw_clear | pulse_clear;
	assign in_sleep  = (st_q == ST_SLEEP);

	// FET overcurrent faults are masked while the disable pin is high
	logic [5:0] fet_oc_live;
	logic       oc_live, ov_live;
	assign fet_oc_live = (driver_disable_pin_s || oc_mode == OC_MODE_OFF) ? 6'h00 : fet_oc_ev;
	assign oc_live     = |fet_oc_live;
	assign ov_live     = ov_en && (ov_sel ? ov34_s : ov22_s);

	// sticky flags; a new event wins over a clear in the same cycle
	logic       pump_undervolt_flag_q, overvolt_flag_q, overcurrent_flag_q;
	logic [5:0] fet_oc_flag_q;
	logic       buck_fault_flag_q, buck_overcurrent_flag_q;
	logic       overtemp_flag_q, thermal_warn_flag_q, thermal_shutdown_flag_q;
	logic       oc_block_q, oc_report_q;

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pump_undervolt_flag_q   <= 1'b0;
			overvolt_flag_q         <= 1'b0;
			thermal_shutdown_flag_q <= 1'b0;
			thermal_warn_flag_q     <= 1'b0;
		end else if (i_ce) begin
			if (in_sleep) begin
				pump_undervolt_flag_q   <= 1'b0;
				overvolt_flag_q         <= 1'b0;
				thermal_shutdown_flag_q <= 1'b0;
				thermal_warn_flag_q     <= 1'b0;
			end else begin
				pump_undervolt_flag_q <= pump_undervolt_protection_s | (pump_undervolt_flag_q & ~clear_any);
				overvolt_flag_q       <= ov_live | (overvolt_flag_q & ~clear_any);
				thermal_shutdown_flag_q <= tsdf_s | tsdd_s
					| (thermal_shutdown_flag_q & ~clear_any);
				// warning needs clear and a cool die to drop
				thermal_warn_flag_q <= warn_s | (thermal_warn_flag_q & ~clear_any);
			end
		end
	end

	// overcurrent response per mode, retry timer shared by mode 01
	logic [CNT_W-1:0] retry_q;
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			overcurrent_flag_q <= 1'b0;
			fet_oc_flag_q      <= 6'h00;
			oc_block_q         <= 1'b0;
			oc_report_q        <= 1'b0;
			retry_q            <= '0;
		end else if (i_ce) begin
			if (in_sleep) begin
				overcurrent_flag_q <= 1'b0;
				fet_oc_flag_q      <= 6'h00;
				oc_block_q         <= 1'b0;
				oc_report_q        <= 1'b0;
				retry_q            <= '0;
			end else begin
				overcurrent_flag_q <= oc_live | (overcurrent_flag_q & ~clear_any);
				fet_oc_flag_q      <= fet_oc_live | (fet_oc_flag_q & {6{~clear_any}});
				case (oc_mode)
					OC_MODE_LATCH: begin
						// bridge stays off until the current is gone and cleared
						if (oc_live) begin
							oc_block_q  <= 1'b1;
							oc_report_q <= 1'b1;
						end else if (clear_any) begin
							oc_block_q  <= 1'b0;
							oc_report_q <= 1'b0;
						end
					end
					OC_MODE_RETRY: begin
						if (oc_live && !oc_block_q) begin
							oc_block_q  <= 1'b1;
							oc_report_q <= 1'b1;
							retry_q     <= '0;
						end else if (oc_block_q) begin
							if (retry_q >= CNT_W'(RETRY_CYCLES - 1)) begin
								oc_block_q  <= 1'b0;
								oc_report_q <= 1'b0;
							end else begin
								retry_q <= retry_q + 1'b1;
							end
						end
					end
					OC_MODE_REPORT: begin
						oc_block_q <= 1'b0;
						if (oc_live) oc_report_q <= 1'b1;
						else if (clear_any) oc_report_q <= 1'b0;
					end
					default: begin
						oc_block_q  <= 1'b0;
						oc_report_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// buck retry: flags and fault end when the retry period runs out
	logic [CNT_W-1:0] bk_retry_q;
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			buck_fault_flag_q       <= 1'b0;
			buck_overcurrent_flag_q <= 1'b0;
			bk_retry_q              <= '0;
		end else if (i_ce) begin
			if (in_sleep) begin
				buck_fault_flag_q       <= 1'b0;
				buck_overcurrent_flag_q <= 1'b0;
				bk_retry_q              <= '0;
			end else if (!buck_overcurrent_flag_q) begin
				if (buck_oc_ev) begin
					buck_fault_flag_q       <= 1'b1;
					buck_overcurrent_flag_q <= 1'b1;
					bk_retry_q              <= '0;
				end
			end else if (bk_retry_q >= CNT_W'(BUCK_RETRY_CYCLES - 1)) begin
				buck_fault_flag_q       <= 1'b0;
				buck_overcurrent_flag_q <= 1'b0;
			end else begin
				bk_retry_q <= bk_retry_q + 1'b1;
			end
		end
	end

	// warning reporting on the fault pin follows hysteresis
	logic warn_rep_q;
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			warn_rep_q <= 1'b0;
		end else if (i_ce) begin
			if (!warn_rep || in_sleep) warn_rep_q <= 1'b0;
			else if (warn_s) warn_rep_q <= 1'b1;
			else if (!warn_hys_s) warn_rep_q <= 1'b0;
		end
	end

	// aggregate flags and outputs; outputs and overtemp flag registered, global fault combinational
	logic overtemp_now, global_fault, fault_req;
	assign overtemp_now = thermal_warn_flag_q | thermal_shutdown_flag_q;
	assign global_fault = pump_undervolt_flag_q | overvolt_flag_q | overcurrent_flag_q
		| buck_fault_flag_q | thermal_shutdown_flag_q;
	assign fault_req = pump_undervolt_protection_s | ov_live | oc_report_q | buck_overcurrent_flag_q
		| tsdf_s | tsdd_s | warn_rep_q;

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_fault_out_n       <= 1'b0;
			o_bridge_enable     <= 1'b0;
			o_buck_enable       <= 1'b0;
			o_pump_enable       <= 1'b0;
			o_regulators_enable <= 1'b0;
			o_ready             <= 1'b0;
			overtemp_flag_q     <= 1'b0;
		end else if (i_ce) begin
			overtemp_flag_q <= overtemp_now;
			// held low while regulators ramp, bounded by wake and entry time
			o_fault_out_n <= operating && !fault_req;
			o_bridge_enable <= operating && !driver_disable_pin_s && !pump_undervolt_protection_s && !ov_live && !oc_block_q
				&& !tsdf_s && !tsdd_s;
			o_pump_enable <= !in_sleep && st_q != ST_ENTER && !tsdf_s && !tsdd_s;
			o_buck_enable <= !in_sleep && st_q != ST_ENTER && !tsdd_s
				&& !buck_overcurrent_flag_q;
			o_regulators_enable <= !in_sleep;
			o_ready <= operating;
		end
	end

	// configuration registers, lost in sleep
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_q  <= CTRL_RESET;
			occfg_q <= OCCFG_RESET;
		end else if (i_ce) begin
			if (in_sleep) begin
				ctrl_q  <= CTRL_RESET;
				occfg_q <= OCCFG_RESET;
			end else if (i_reg_wr && operating) begin
				if (i_reg_addr == ADDR_CTRL) ctrl_q <= {5'h00, i_reg_wdata[2:0]};
				if (i_reg_addr == ADDR_OCCFG) occfg_q <= {4'h0, i_reg_wdata[3:0]};
			end
		end
	end

	// read data valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_reg_rdata <= 8'h00;
		end else if (i_ce) begin
			o_reg_rdata <= 8'h00;
			if (i_reg_rd && operating) begin
				case (i_reg_addr)
					ADDR_STATUS: o_reg_rdata <= {1'b0, buck_fault_flag_q, 1'b0, overcurrent_flag_q,
						1'b1, overvolt_flag_q, overtemp_flag_q, global_fault};
					ADDR_FET_OC: o_reg_rdata <= {2'h0, fet_oc_flag_q};
					ADDR_STAT2:  o_reg_rdata <= {3'h0, buck_overcurrent_flag_q,
						thermal_shutdown_flag_q, thermal_warn_flag_q, pump_undervolt_flag_q, 1'b0};
					ADDR_CTRL:   o_reg_rdata <= ctrl_q;
					ADDR_OCCFG:  o_reg_rdata <= occfg_q;
					default:     o_reg_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule

// file: sim/fault_mgr_monitor.sv
// port assertions for the fault manager
`timescale 1ns/100ps
module fault_mgr_monitor #(
	parameter int SLEEP_CYCLES     = 16,
	parameter int WAKE_CYCLES      = 16,
	parameter int RST_PULSE_CYCLES = 12
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_sleep_n,
	input wire logic i_driver_disable_pin,
	input wire logic i_pump_uv,
	input wire logic i_buck_oc,
	input wire logic i_tsd_fet,
	input wire logic i_tsd_die,
	input wire logic o_fault_out_n,
	input wire logic o_bridge_enable,
	input wire logic o_buck_enable,
	input wire logic o_pump_enable,
	input wire logic o_regulators_enable,
	input wire logic o_ready
);
	localparam int WAKE_MAX = WAKE_CYCLES + 8;
	localparam int LOW_LIM  = RST_PULSE_CYCLES + SLEEP_CYCLES + 8;
	logic [7:0] low_cnt_q;
	logic [7:0] buck_cnt_q;
	// run lengths of sleep pin low and buck overcurrent; saturate so a long hold never wraps
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			low_cnt_q  <= 8'h00;
			buck_cnt_q <= 8'h00;
		end else begin
			low_cnt_q  <= i_sleep_n ? 8'h00 : low_cnt_q + {7'h00, low_cnt_q != 8'hff};
			buck_cnt_q <= !i_buck_oc ? 8'h00 : buck_cnt_q + {7'h00, buck_cnt_q != 8'hff};
		end
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	// a reset pulse: falls while ready, five cycles low, back high
	sequence s_short_low;
		o_ready ##0 $fell(i_sleep_n) ##1 !i_sleep_n [*4] ##1 i_sleep_n;
	endsequence
	sequence s_wake;
		$rose(o_regulators_enable);
	endsequence
	AST_PUMP_TRIP: assert property (i_pump_uv [*4] |=> !o_bridge_enable && !o_fault_out_n)
		else $error("pump undervoltage left the bridge on");
	AST_FET_HOT: assert property (i_tsd_fet [*4] |=> !o_bridge_enable && !o_pump_enable && !o_fault_out_n)
		else $error("fet shutdown left bridge or pump on");
	AST_DIE_HOT: assert property (i_tsd_die [*4] |=> !o_buck_enable && !o_bridge_enable && !o_pump_enable)
		else $error("die shutdown left buck, bridge or pump on");
	AST_DRV_OFF: assert property (i_driver_disable_pin [*4] |=> !o_bridge_enable)
		else $error("driver disable left the bridge on");
	AST_BUCK_TRIP: assert property (buck_cnt_q == 8'd40 |-> !o_buck_enable && !o_fault_out_n)
		else $error("buck overcurrent left the buck on");
	AST_SLEEP_IN: assert property (low_cnt_q == LOW_LIM |-> !o_regulators_enable && !o_ready)
		else $error("long low on sleep pin did not sleep");
	AST_WAKE_TIME: assert property (s_wake |-> ##[1:WAKE_MAX] o_ready)
		else $error("ready late after wake");
	AST_RAMP_LOW: assert property (s_wake |-> !o_fault_out_n)
		else $error("fault pin high while regulators ramp");
	AST_PULSE_KEEP: assert property (s_short_low |-> ##1 o_regulators_enable [*8])
		else $error("reset pulse disturbed the regulators");
endmodule

bind motor_driver_fault_manager fault_mgr_monitor #(
	.SLEEP_CYCLES(SLEEP_CYCLES), .WAKE_CYCLES(WAKE_CYCLES), .RST_PULSE_CYCLES(RST_PULSE_CYCLES)
) i_fault_mgr_monitor (
	.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_sleep_n(i_sleep_n),
	.i_driver_disable_pin(i_driver_disable_pin), .i_pump_uv(i_pump_uv), .i_buck_oc(i_buck_oc),
	.i_tsd_fet(i_tsd_fet), .i_tsd_die(i_tsd_die), .o_fault_out_n(o_fault_out_n),
	.o_bridge_enable(o_bridge_enable), .o_buck_enable(o_buck_enable),
	.o_pump_enable(o_pump_enable), .o_regulators_enable(o_regulators_enable), .o_ready(o_ready)
);

// file: sim/mcu_model.sv
// controller model driving the sleep and driver disable pins
`timescale 1ns/100ps
module mcu_model #(
	parameter int WAKE_CYCLES = 16
) (
	input  wire logic i_clk_sys,
	input  wire logic i_ready,
	output logic      o_sleep_n,
	output logic      o_drv_off
);
	initial begin
		o_sleep_n = 1'b1;
		o_drv_off = 1'b0;
	end
	// five low cycles, well inside the reset window so no sleep starts
	task automatic reset_pulse();
		@(posedge i_clk_sys) o_sleep_n <= 1'b0;
		repeat (5) @(posedge i_clk_sys);
		o_sleep_n <= 1'b1;
	endtask
	task automatic sleep(input int n);
		@(posedge i_clk_sys) o_sleep_n <= 1'b0;
		repeat (n) @(posedge i_clk_sys);
	endtask
	// no inputs until the device reports ready; bounded in case it never does
	task automatic wake();
		@(posedge i_clk_sys) o_sleep_n <= 1'b1;
		for (int i = 0; i < WAKE_CYCLES + 60 && i_ready !== 1'b1; i++) @(posedge i_clk_sys);
	endtask
	task automatic set_off(input logic v);
		@(posedge i_clk_sys) o_drv_off <= v;
	endtask
endmodule

// file: sim/motor_driver_fault_manager_tb.sv
// self-checking bench for the fault manager
`timescale 1ns/100ps
module motor_driver_fault_manager_tb;
	import fault_mgr_pkg::*;
	localparam int RTY = 20;
	logic       clk, rst_b, slp_n, off, puv, v22, v34, boc, tw, th, tf, td, wr, rd;
	logic       flt_n, brg, bck, pmp, rgl, rdy, ce, pinv;
	logic [5:0] foc;
	logic [4:0] addr;
	logic [7:0] wdat, rdat;
	logic [3:0] e;
	int         n_errors, samples_checked, k, seed;
	motor_driver_fault_manager #(.RETRY_CYCLES(RTY), .BUCK_RETRY_CYCLES(RTY),
		.SLEEP_CYCLES(16), .WAKE_CYCLES(16), .RST_PULSE_CYCLES(12)) i_motor_driver_fault_manager (
		.i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(ce), .i_pin_variant(pinv), .i_sleep_n(slp_n),
		.i_driver_disable_pin(off), .i_pump_uv(puv), .i_vm_above_22(v22), .i_vm_above_34(v34),
		.i_fet_oc(foc), .i_buck_oc(boc), .i_temp_warn(tw), .i_temp_warn_hys(th), .i_tsd_fet(tf),
		.i_tsd_die(td), .i_reg_addr(addr), .i_reg_wdata(wdat), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdat), .o_fault_out_n(flt_n), .o_bridge_enable(brg), .o_buck_enable(bck),
		.o_pump_enable(pmp), .o_regulators_enable(rgl), .o_ready(rdy));
	mcu_model i_mcu_model (.i_clk_sys(clk), .i_ready(rdy),
		.o_sleep_n(slp_n), .o_drv_off(off));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// wait n edges, then let that edge's updates land before looking
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wreg(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdat, exp);
	endtask
	task automatic note(input string s);
		$display("test %s done at %0t", s, $time);
	endtask
	// pin levels {bridge, fault} during and after an overcurrent for each mode
	function automatic logic [3:0] oc_exp(input logic [1:0] m);
		case (m)
			OC_MODE_LATCH: return 4'b0000;
			OC_MODE_RETRY: return 4'b0011;
			OC_MODE_REPORT: return 4'b1010;
			default: return 4'b1111;
		endcase
	endfunction
	task automatic complete_run();
		$display("compared %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// watchdog, several times the expected run
	initial begin
		#200000;
		n_errors++;
		$display("Error at %0t: timeout", $time);
		complete_run();
	end
	initial begin
		seed = 32'h11d72a90;
		{puv, v22, v34, foc, boc, tw, th, tf, td, addr, wdat, wr, rd} = '0;
		ce = 1'b1;
		pinv = 1'b0;
		n_errors = 0;
		samples_checked = 0;
		rst_b = 1'b0;
		cyc(20);
		rst_b <= 1'b1;
		for (int i = 0; i < 300 && rdy !== 1'b1; i++) cyc(1);
		cyc(2);
		chk({6'h00, brg, flt_n}, 8'h03);
		rchk(5'h00, 8'h08);
		rchk(5'd6 + 5'($unsigned($random(seed)) % 26), 8'h00);
		// pump undervoltage trips, recovers, flag held until cleared
		puv <= 1'b1;
		cyc(8);
		chk({6'h00, brg, flt_n}, 8'h00);
		puv <= 1'b0;
		cyc(8);
		chk({6'h00, brg, flt_n}, 8'h03);
		rchk(5'h02, 8'h02);
		rchk(5'h00, 8'h09);
		wreg(5'h05, 8'h01);
		rchk(5'h02, 8'h00);
		note("pump");
		// overvoltage off, then at each threshold
		v22 <= 1'b1;
		cyc(8);
		chk({6'h00, brg, flt_n}, 8'h03);
		wreg(5'h03, 8'h01);
		cyc(8);
		chk({6'h00, brg, flt_n}, 8'h00);
		wreg(5'h03, 8'h03);
		cyc(8);
		chk({6'h00, brg, flt_n}, 8'h03);
		v34 <= 1'b1;
		cyc(8);
		chk({6'h00, brg, flt_n}, 8'h00);
		v22 <= 1'b0;
		v34 <= 1'b0;
		wreg(5'h03, 8'h00);
		cyc(8);
		rchk(5'h00, 8'h0d);
		wreg(5'h05, 8'h01);
		note("overvoltage");
		// a glitch shorter than the deglitch time, then every response mode
		foc <= 6'h3f;
		cyc(10);
		foc <= 6'h00;
		cyc(6);
		chk({6'h00, brg, flt_n}, 8'h03);
		// doubled deglitch setting filters a pulse that the base time would catch
		wreg(5'h04, 8'h04);
		foc <= 6'h3f;
		cyc(45);
		foc <= 6'h00;
		cyc(6);
		chk({6'h00, brg, flt_n}, 8'h03);
		for (int m = 0; m < 4; m++) begin
			wreg(5'h04, {6'h00, m[1:0]});
			k = $unsigned($random(seed)) % 6;
			foc <= 6'h01 << k;
			cyc(40);
			e = oc_exp(m[1:0]);
			chk({6'h00, brg, flt_n}, {6'h00, e[3:2]});
			foc <= 6'h00;
			cyc(RTY + 10);
			chk({6'h00, brg, flt_n}, {6'h00, e[1:0]});
			rchk(5'h01, m == 3 ? 8'h00 : 8'h01 << k);
			wreg(5'h05, 8'h01);
			cyc(3);
			chk({6'h00, brg, flt_n}, 8'h03);
		end
		note("overcurrent");
		// thermal warning, unreported and reported
		tw <= 1'b1;
		th <= 1'b1;
		cyc(8);
		chk({6'h00, brg, flt_n}, 8'h03);
		rchk(5'h02, 8'h04);
		wreg(5'h03, 8'h04);
		cyc(4);
		chk({6'h00, brg, flt_n}, 8'h02);
		tw <= 1'b0;
		cyc(8);
		chk({6'h00, brg, flt_n}, 8'h02);
		th <= 1'b0;
		cyc(8);
		chk({6'h00, brg, flt_n}, 8'h03);
		wreg(5'h05, 8'h01);
		rchk(5'h02, 8'h00);
		// fet sensor then die sensor shutdown
		for (int j = 0; j < 2; j++) begin
			tf <= (j == 0);
			td <= (j == 1);
			cyc(8);
			chk({4'h0, bck, pmp, brg, flt_n}, {4'h0, j == 0, 3'b000});
			tf <= 1'b0;
			td <= 1'b0;
			cyc(8);
			rchk(5'h02, 8'h08);
			wreg(5'h05, 8'h01);
		end
		// buck overcurrent retries and its flags expire on their own
		boc <= 1'b1;
		cyc(40);
		chk({6'h00, bck, flt_n}, 8'h00);
		boc <= 1'b0;
		rchk(5'h00, 8'h49);
		cyc(RTY + 20);
		chk({6'h00, bck, flt_n}, 8'h03);
		rchk(5'h02, 8'h00);
		note("thermal and buck");
		// driver disable hides an overcurrent in latch mode
		wreg(5'h04, 8'h00);
		i_mcu_model.set_off(1'b1);
		foc <= 6'h3f;
		cyc(40);
		chk({6'h00, brg, flt_n}, 8'h01);
		foc <= 6'h00;
		rchk(5'h01, 8'h00);
		i_mcu_model.set_off(1'b0);
		cyc(6);
		chk({6'h00, brg, flt_n}, 8'h03);
		// clock enable low freezes everything, so a warning waits for it
		ce <= 1'b0;
		tw <= 1'b1;
		th <= 1'b1;
		cyc(8);
		chk({6'h00, brg, flt_n}, 8'h03);
		ce <= 1'b1;
		cyc(8);
		chk({6'h00, brg, flt_n}, 8'h02);
		tw <= 1'b0;
		th <= 1'b0;
		cyc(8);
		chk({6'h00, brg, flt_n}, 8'h03);
		wreg(5'h05, 8'h01);
		// pin variant: overvoltage forced on at 34 V, clear bit ignored
		pinv <= 1'b1;
		v34 <= 1'b1;
		cyc(8);
		chk({6'h00, brg, flt_n}, 8'h00);
		v34 <= 1'b0;
		cyc(8);
		wreg(5'h05, 8'h01);
		rchk(5'h00, 8'h0d);
		note("enable and variant");
		// reset pulse clears held flags on the pin variant and keeps settings
		puv <= 1'b1;
		cyc(8);
		puv <= 1'b0;
		cyc(8);
		i_mcu_model.reset_pulse();
		cyc(8);
		rchk(5'h02, 8'h00);
		rchk(5'h00, 8'h08);
		rchk(5'h03, 8'h04);
		chk({6'h00, rgl, rdy}, 8'h03);
		pinv <= 1'b0;
		// long low sleeps, then wake restores defaults
		i_mcu_model.sleep(48);
		cyc(1);
		chk({5'h00, rgl, rdy, brg}, 8'h00);
		i_mcu_model.wake();
		cyc(2);
		chk({6'h00, rdy, flt_n}, 8'h03);
		rchk(5'h03, 8'h00);
		note("sleep");
		complete_run();
	end
endmodule
